// ==== rtl/gpa_apb.v ====
// APB slave decode and access strobes for the port registers
`timescale 1ns/1ns
`default_nettype none
`include "gpa_map.vh"
module gpa_apb (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  output wire acc_stb,
  output wire wr_dir,
  output wire wr_dat,
  output wire rd_dir,
  output wire rd_dat,
  output wire bad_addr
);
  wire [`GPA_ADDR_W-1:0] a_low;
  wire hit_dir;
  wire hit_dat;
  assign a_low = paddr[`GPA_ADDR_W-1:0];
  assign acc_stb = psel & penable;
  assign hit_dir = (a_low == `GPA_DIR_ADDR);
  assign hit_dat = (a_low == `GPA_DAT_ADDR);
  assign wr_dir = acc_stb & pwrite & hit_dir;
  assign wr_dat = acc_stb & pwrite & hit_dat;
  assign rd_dir = acc_stb & ~pwrite & hit_dir;
  assign rd_dat = acc_stb & ~pwrite & hit_dat;
  assign bad_addr = acc_stb & ~hit_dir & ~hit_dat;
endmodule // gpa_apb
`default_nettype wire

// ==== rtl/gpa_map.vh ====
// Register map and constants for the eight-bit port A block
// Contract
// - Reset or hardware standby leaves all pins input, except pin 7 address in modes 3,4,6; in hardware standby the code drives pin 7 low as output.
// - Direction bit 1 makes the pin output, 0 makes it input.
// - Modes 3,4,6 hold direction bit 7 at 1 and drive pin 7 as address.
// - Direction register is write-only; reads return all ones.
// - Modes 1,2,5,7 initialise direction to zero on reset and hardware standby.
// - Modes 3,4,6 initialise direction to only bit 7 set.
// - Software standby keeps direction; output pins keep driving their state.
// - Data register is an 8-bit read/write latch for pins 7 to 0.
// - Reading the port returns latched data for output-direction bits.
// - Reading the port returns live pin level for input-direction bits.
// - Data register clears on reset and hardware standby, kept in software standby.
// - Pins not claimed by other functions act as plain general-purpose I/O.
// - Direction register at 3FF44 (index FFD1), data register at 3FF4C (index FFD3), low 18 address bits.
`ifndef GPA_MAP_VH
`define GPA_MAP_VH
`define GPA_DIR_IDX 16'hFFD1
`define GPA_DAT_IDX 16'hFFD3
`define GPA_DIR_ADDR 18'h3FF44
`define GPA_DAT_ADDR 18'h3FF4C
`define GPA_ADDR_W 18
`define GPA_DIR_RST_LOW 8'h00
`define GPA_DIR_RST_ADDR 8'h80
`define GPA_DAT_RST 8'h00
`define GPA_DIR_READ 8'hFF
`define GPA_TOP_BIT 7
`define GPA_MODE_W 3
`endif

// ==== rtl/gpa_port.v ====
// Eight-bit general-purpose I/O port A with APB register access
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "gpa_map.vh"
module gpa_port (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] mode_sel,
  input wire hw_standby,
  input wire sw_standby,
  input wire address_bit_twenty_output,
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe
);
  reg [7:0] port_direction_ff;
  reg [7:0] port_output_latch_ff;
  reg [7:0] nxt_port_direction;
  reg [7:0] nxt_port_output_latch;
  reg [7:0] nxt_pin_out;
  reg [7:0] nxt_pin_oe;
  reg [31:0] nxt_prdata;
  reg [2:0] mode_ff;
  reg hold_ff;
  wire [7:0] pin_level;
  wire acc_stb;
  wire wr_dir;
  wire wr_dat;
  wire rd_dir;
  wire rd_dat;
  wire bad_addr;
  wire addr_mode;
  wire [7:0] dir_init;
  wire [7:0] port_view;

  // Modes in which the top pin carries address bit twenty
  function is_addr_mode;
    input [2:0] m;
    begin
      is_addr_mode = (m == 3'h3) || (m == 3'h4) || (m == 3'h6);
    end
  endfunction

  gpa_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(pin_in),
    .level_ff(pin_level)
  );

  gpa_apb u_apb (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .acc_stb(acc_stb),
    .wr_dir(wr_dir),
    .wr_dat(wr_dat),
    .rd_dir(rd_dir),
    .rd_dat(rd_dat),
    .bad_addr(bad_addr)
  );

  // Mode strap captured after reset release and in hardware standby
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= 3'h0;
      hold_ff <= 1'b1;
    end else if (hold_ff || hw_standby) begin
      mode_ff <= mode_sel;
      hold_ff <= 1'b0;
    end
  end

  assign addr_mode = is_addr_mode(mode_ff);
  assign dir_init = is_addr_mode(mode_sel) ? `GPA_DIR_RST_ADDR : `GPA_DIR_RST_LOW;
  assign port_view = (port_direction_ff & port_output_latch_ff) | (~port_direction_ff & pin_level);

  always @* begin
    nxt_port_direction = port_direction_ff;
    nxt_port_output_latch = port_output_latch_ff;
    if (hw_standby || hold_ff) begin
      nxt_port_direction = dir_init;
      nxt_port_output_latch = `GPA_DAT_RST;
    end else begin
      // Software standby: no change unless the bus writes
      // Writes land only at the edge that completes the access
      if (wr_dir && pready) begin
        nxt_port_direction = pwdata[7:0];
      end
      if (wr_dat && pready) begin
        nxt_port_output_latch = pwdata[7:0];
      end
      if (addr_mode) begin
        nxt_port_direction[`GPA_TOP_BIT] = 1'b1;
      end
    end
  end

  always @* begin
    nxt_prdata = 32'h0000_0000;
    if (rd_dir) begin
      nxt_prdata = {24'h000000, `GPA_DIR_READ};
    end else if (rd_dat) begin
      nxt_prdata = {24'h000000, port_view};
    end
  end

  // Pin drive: direction is enable, latch is value; top pin to address
  always @* begin
    nxt_pin_oe = nxt_port_direction;
    nxt_pin_out = nxt_port_output_latch;
    if (addr_mode && !(hw_standby || hold_ff)) begin
      nxt_pin_oe[`GPA_TOP_BIT] = 1'b1;
      nxt_pin_out[`GPA_TOP_BIT] = address_bit_twenty_output;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_direction_ff <= `GPA_DIR_RST_LOW;
      port_output_latch_ff <= `GPA_DAT_RST;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
    end else begin
      port_direction_ff <= nxt_port_direction;
      port_output_latch_ff <= nxt_port_output_latch;
      pin_out <= nxt_pin_out;
      pin_oe <= nxt_pin_oe;
    end
  end

  // One wait state: answer one cycle after the access phase starts
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (acc_stb && !pready) begin
      pready <= 1'b1;
      pslverr <= bad_addr;
      prdata <= nxt_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end
endmodule // gpa_port
`default_nettype wire

// ==== rtl/gpa_sync.v ====
// Three-stage pin synchroniser for the port inputs
`timescale 1ns/1ns
`default_nettype none
module gpa_sync (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] pin_in,
  output reg [7:0] level_ff
);
  reg [7:0] s1_ff;
  reg [7:0] s2_ff;
  reg [7:0] s3_ff;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bit
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
          s3_ff[g] <= 1'b0;
          level_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= pin_in[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          // Change accepted once stages two and three agree
          if (s2_ff[g] == s3_ff[g]) begin
            level_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate
endmodule // gpa_sync
`default_nettype wire

// ==== testbench/gpa_board.sv ====
// Board circuitry model on the port pins
`timescale 1ns/1ns
`default_nettype none
module gpa_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // Driven pins read back, released pins show the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gpa_board
`default_nettype wire

// ==== testbench/gpa_props_properties.sv ====
// Assertion checker for the port A block
`timescale 1ns/1ns
`default_nettype none
`include "gpa_map.vh"
module gpa_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] mode_sel,
  input wire logic hw_standby,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe
);
  logic [7:0] ini;
  logic ad, aq;
  assign ini = {mode_sel == 3'h3 || mode_sel == 3'h4 || mode_sel == 3'h6, 7'h0};
  assign ad = pready && paddr[17:0] == `GPA_DIR_ADDR;
  assign aq = pready && paddr[17:0] == `GPA_DAT_ADDR;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst; $rose(rst_n) |=> ##1 pin_oe == ini; endproperty
  a_rst: assert property (p_rst) else $error("init");
  property p_hws; hw_standby |-> ##2 pin_oe == ini && pin_out[6:0] == 7'h0; endproperty
  a_hws: assert property (p_hws) else $error("hws");
  property p_top; ini[7] && $past(rst_n, 2) |-> pin_oe[7]; endproperty
  a_top: assert property (p_top) else $error("top");
  property p_drd; ad && !pwrite |-> prdata == 32'hFF; endproperty
  a_drd: assert property (p_drd) else $error("drd");
  property p_unm; pready && !ad && !aq |-> pslverr && prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unm");
  property p_dwr; ad && pwrite && !hw_standby |=> pin_oe[6:0] == $past(pwdata[6:0]); endproperty
  a_dwr: assert property (p_dwr) else $error("dwr");
  property p_qwr; aq && pwrite && !hw_standby |=> pin_out[6:0] == $past(pwdata[6:0]); endproperty
  a_qwr: assert property (p_qwr) else $error("qwr");
  property p_qrd; aq && !pwrite && !hw_standby |-> ((prdata[6:0] ^ pin_out[6:0]) & pin_oe[6:0]) == 7'h0; endproperty
  a_qrd: assert property (p_qrd) else $error("qrd");
  c_unm: cover property (pready && pslverr);
  c_hws: cover property (hw_standby && pin_oe[7]);
  c_qrd: cover property (aq && !pwrite);
endmodule // gpa_props
bind gpa_port gpa_props chk_u (.*);
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the port A block
`timescale 1ns/1ns
`default_nettype none
`include "gpa_map.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; $display("BAD %s %h %h", n, e, s); end end
module testbench;
  logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, hw_standby = 1'h0;
  logic sw_standby = 1'h0, address_bit_twenty_output = 1'h1, pready, pslverr, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [2:0] mode_sel = 3'h1;
  logic [7:0] pin_in, pin_out, pin_oe, ini, dir, pv, ext_level = 8'hA5;
  int num_errors = 0, num_checks = 0;
  gpa_port dut_u (.*);
  gpa_board brd_u (.*);
  always #2 ref_clk = ~ref_clk;
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      num_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdq(input logic [7:0] e);
    apb(1'h0, `GPA_DAT_ADDR, 32'h0);
    `CHK("port", e, rd[7:0])
  endtask
  initial begin
    for (int m = 1; m < 8; m++) begin
      ini = {m == 3 || m == 4 || m == 6, 7'h0};
      dir = ini | 8'h7F;
      pv = (dir & 8'h3C) | (~dir & ext_level);
      mode_sel <= m[2:0];
      rst_n <= 1'h0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge ref_clk);
      `CHK("oe", ini, pin_oe)
      apb(1'h0, `GPA_DIR_ADDR, 32'h0);
      `CHK("dir", 32'hFF, rd)
      rdq(ext_level & ~ini);
      apb(1'h1, `GPA_DIR_ADDR, 32'h7F);
      apb(1'h1, `GPA_DAT_ADDR, 32'h3C);
      repeat (2) @(posedge ref_clk);
      `CHK("oe", dir, pin_oe)
      `CHK("out", ini | 8'h3C, pin_out)
      address_bit_twenty_output <= 1'h0;
      repeat (2) @(posedge ref_clk);
      `CHK("out", 8'h3C, pin_out)
      address_bit_twenty_output <= 1'h1;
      rdq(pv);
      apb(1'h0, 32'h100, 32'h0);
      `CHK("err", 33'h100000000, {err, rd})
      sw_standby <= 1'h1;
      rdq(pv);
      `CHK("oe", dir, pin_oe)
      sw_standby <= 1'h0;
      hw_standby <= 1'h1;
      apb(1'h1, `GPA_DAT_ADDR, 32'hFF);
      hw_standby <= 1'h0;
      repeat (5) @(posedge ref_clk);
      `CHK("oe", ini, pin_oe)
      rdq(ext_level & ~ini);
      $display("mode %0d done", m);
    end
    final_report();
  end
endmodule // testbench
`default_nettype wire
